// file: safe_io_gating.sv
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "safe_io_params.svh"

module safe_io_gating #(
   parameter int          NSAFE    = `SIO_NSAFE,
   parameter int          NGROUP   = `SIO_NGROUP,
   parameter int          NUNIT    = `SIO_NUNIT,
   parameter int          NKEY     = `SIO_NKEY,
   parameter logic [15:0] SCAN_CYC = 16'(`SIO_SCAN_TIME_US * (`SIO_CLK_HZ / 1000000)),
   parameter logic [15:0] TEST_CYC = 16'(`SIO_TEST_TIME_US * (`SIO_CLK_HZ / 1000000)),
   parameter logic [47:0] ST_CYC   = 48'(64'(`SIO_SELFTEST_H) * 64'd3600 * 64'(`SIO_CLK_HZ))
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      arst_n,
   // APB slave
   input  wire safe_io_pkg::apb_req_type  apb_req,
   output safe_io_pkg::apb_rsp_type       apb_rsp,
   // Field contacts, channel A and channel B
   input  wire safe_io_pkg::marker_type   contact_a,
   input  wire safe_io_pkg::marker_type   contact_b,
   // Test supply outputs feeding the contacts
   output logic                           test_out_a,
   output logic                           test_out_b,
   // Channel computers
   output safe_io_pkg::marker_type        marker_a,
   output safe_io_pkg::marker_type        marker_b,
   output logic [7:0]                     view_a_own,
   output logic [7:0]                     view_a_other,
   output logic [7:0]                     view_b_own,
   output logic [7:0]                     view_b_other,
   input  wire logic                      sw_crash,
   // Safety kernel
   input  wire logic                      all_standstill,
   input  wire logic                      stop_ack_a,
   input  wire logic                      stop_ack_b,
   output logic                           controlled_stop_a,
   output logic                           controlled_stop_b,
   output logic                           controlled_stop_fault,
   output logic [3:0]                     group_guard_req,
   output logic [3:0]                     group_permit,
   // Safe outputs, both channels
   output logic [3:0]                     safe_out_a,
   output logic [3:0]                     safe_out_b,
   // Operating units
   input  wire logic [15:0]               keys_in,
   output logic [15:0]                    key_marker,
   output logic [1:0]                     unit_active
);
   if (NSAFE != `SIO_NSAFE || NGROUP != `SIO_NGROUP || NUNIT != `SIO_NUNIT ||
       NKEY != `SIO_NKEY || SCAN_CYC == 16'h0000 || TEST_CYC < 16'h0003) begin : g_bad_param
      $error("safe_io_gating: unsupported parameter values");
   end

   safe_io_pkg::state_type s_r, s_nxt;

   logic [7:0] raw_a, raw_b, vw_a, vw_b, comb, skip_a, skip_b;
   logic       wr, rd, scan_tick, trip, unit_ok;

   // only configured inputs are tested; their contacts hang on test_out
   assign skip_a = (s_r.tst == safe_io_pkg::T_CHAN_A) ? s_r.fsamp : 8'h00;
   assign skip_b = (s_r.tst == safe_io_pkg::T_CHAN_B) ? s_r.fsamp : 8'h00;

   for (genvar i = 0; i < NSAFE; i++) begin : g_pair
      safe_chan_pair u_pair (
         .clk      (clk),
         .arst_n   (arst_n),
         .pin_a    (contact_a[i]),
         .pin_b    (contact_b[i]),
         .inv_a    (s_r.inv_a[i]),
         .inv_b    (s_r.inv_b[i]),
         .skip_a   (skip_a[i]),
         .skip_b   (skip_b[i]),
         .raw_a    (raw_a[i]),
         .raw_b    (raw_b[i]),
         .view_a   (vw_a[i]),
         .view_b   (vw_b[i]),
         .combined (comb[i])
      );
   end

   assign wr        = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign rd        = apb_req.psel & ~apb_req.pwrite;
   assign scan_tick = (s_r.scan_cnt == SCAN_CYC - 16'h0001);
   // either estop channel low trips at once, not waiting for the scan
   assign trip      = ~&comb[7:6];

   always_comb begin
      s_nxt = s_r;
      s_nxt.scan_cnt = scan_tick ? 16'h0000 : s_r.scan_cnt + 16'h0001;

      // Register writes
      if (wr) begin
         unique case (apb_req.paddr)
            `SIO_REG_INV_A:    s_nxt.inv_a = apb_req.pwdata[7:0];
            `SIO_REG_INV_B:    s_nxt.inv_b = apb_req.pwdata[7:0];
            `SIO_REG_FSAMP:    s_nxt.fsamp = apb_req.pwdata[7:0];
            `SIO_REG_MODE: begin
               s_nxt.hw_mode  = apb_req.pwdata[`SIO_MODE_HW_BIT];
               s_nxt.unit_sel = apb_req.pwdata[`SIO_MODE_UNIT_BIT];
            end
            `SIO_REG_SAFEOUT:  s_nxt.out_req   = apb_req.pwdata[3:0];
            `SIO_REG_TIMEOUT:  s_nxt.timeout   = apb_req.pwdata;
            `SIO_REG_GROUPMAP: s_nxt.group_map = apb_req.pwdata[7:0];
            `SIO_REG_PBMAP:    s_nxt.pb_map    = apb_req.pwdata[7:0];
            `SIO_REG_STATUS: begin
               if (apb_req.pwdata[`SIO_STAT_FAIL_BIT]) begin
                  s_nxt.tst_fail = 1'b0;
               end
               if (apb_req.pwdata[`SIO_STAT_MISM_BIT]) begin
                  s_nxt.mismatch = 1'b0;
               end
            end
            default: ;
         endcase
      end

      // filter keys and refresh all markers on the same scan tick
      if (scan_tick) begin
         s_nxt.marker = comb;
         for (int u = 0; u < NUNIT; u++) begin
            // stop keys pass from every unit
            s_nxt.keys[u*NKEY +: NKEY] = keys_in[u*NKEY +: NKEY] &
               (((u == int'(s_r.unit_sel)) ? 8'hff : 8'h00) | `SIO_STOP_KEY_MASK);
         end
      end
      if (trip) begin
         s_nxt.marker.estop = comb[7:6];
      end

      // self-test at most every interval, or on software request
      // test supplies otherwise stay static high
      s_nxt.st_cnt = s_r.st_cnt + 48'h1;
      unique case (s_r.tst)
         safe_io_pkg::T_IDLE: begin
            if (s_r.st_cnt >= ST_CYC - 48'h1 ||
                (wr && apb_req.paddr == `SIO_REG_MODE && apb_req.pwdata[`SIO_MODE_TEST_BIT])) begin
               s_nxt.tst     = safe_io_pkg::T_CHAN_A;
               s_nxt.tst_cnt = 16'h0000;
               s_nxt.st_cnt  = 48'h0;
            end
         end
         safe_io_pkg::T_CHAN_A, safe_io_pkg::T_CHAN_B: begin
            s_nxt.tst_cnt = s_r.tst_cnt + 16'h0001;
            if (s_r.tst_cnt == TEST_CYC - 16'h0001) begin
               // Unpowered contact must read zero on the channel under test
               if (((s_r.tst == safe_io_pkg::T_CHAN_A ? raw_a : raw_b) & s_r.fsamp) != 8'h00) begin
                  s_nxt.tst_fail = 1'b1;
               end
               s_nxt.tst_cnt = 16'h0000;
               s_nxt.tst = (s_r.tst == safe_io_pkg::T_CHAN_A) ? safe_io_pkg::T_CHAN_B
                                                               : safe_io_pkg::T_IDLE;
            end
         end
         default: s_nxt.tst = safe_io_pkg::T_IDLE;
      endcase

      // estop or crash latches the stop; release needs a clear with no cause
      if (trip || sw_crash) begin
         s_nxt.stop       = 1'b1;
         s_nxt.stop_fault = s_r.stop_fault | sw_crash;
      end else if (wr && apb_req.paddr == `SIO_REG_MODE && apb_req.pwdata[`SIO_MODE_CLR_BIT]) begin
         s_nxt.stop       = 1'b0;
         s_nxt.stop_fault = 1'b0;
      end

      // during a stop, outputs off at standstill or when the timer expires
      if (!s_r.stop) begin
         s_nxt.off_cnt = 32'h0;
         s_nxt.out_off = 1'b0;
      end else begin
         if (s_r.off_cnt != 32'hffff_ffff) begin
            s_nxt.off_cnt = s_r.off_cnt + 32'h1;
         end
         if (all_standstill || s_r.off_cnt >= s_r.timeout) begin
            s_nxt.out_off = 1'b1;
         end
      end

      if (stop_ack_a != stop_ack_b) begin
         s_nxt.mismatch = 1'b1;
      end

      // Read data, registered for the access phase
      s_nxt.rsp_err = 1'b0;
      s_nxt.rdata   = 32'h0;
      if (rd) begin
         unique case (apb_req.paddr)
            `SIO_REG_INV_A:    s_nxt.rdata[7:0] = s_r.inv_a;
            `SIO_REG_INV_B:    s_nxt.rdata[7:0] = s_r.inv_b;
            `SIO_REG_FSAMP:    s_nxt.rdata[7:0] = s_r.fsamp;
            `SIO_REG_MODE:     s_nxt.rdata[1:0] = {s_r.unit_sel, s_r.hw_mode};
            `SIO_REG_SAFEOUT:  s_nxt.rdata[3:0] = s_r.out_req;
            `SIO_REG_TIMEOUT:  s_nxt.rdata      = s_r.timeout;
            `SIO_REG_GROUPMAP: s_nxt.rdata[7:0] = s_r.group_map;
            `SIO_REG_PBMAP:    s_nxt.rdata[7:0] = s_r.pb_map;
            `SIO_REG_STATUS:   s_nxt.rdata[5:0] = {s_r.mismatch, s_r.tst_fail,
                                                  s_r.tst != safe_io_pkg::T_IDLE,
                                                  s_r.out_off, s_r.stop_fault, s_r.stop};
            `SIO_REG_MARKERS:  s_nxt.rdata[7:0] = s_r.marker;
            `SIO_REG_RAW:      s_nxt.rdata      = {8'h00, raw_b, 8'h00, raw_a};
            default:           s_nxt.rsp_err    = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r         <= '0;
         s_r.timeout <= `SIO_TIMEOUT_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // No wait state: read data is captured in the setup cycle
   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = s_r.rsp_err & apb_req.psel & apb_req.penable;
   assign apb_rsp.prdata  = s_r.rdata;

   assign test_out_a = (s_r.tst != safe_io_pkg::T_CHAN_A);
   assign test_out_b = (s_r.tst != safe_io_pkg::T_CHAN_B);

   // both computers see the same combined markers
   assign marker_a = s_r.marker;
   assign marker_b = s_r.marker;
   // each computer sees its own and the other channel
   assign view_a_own   = vw_a;
   assign view_a_other = vw_b;
   assign view_b_own   = vw_b;
   assign view_b_other = vw_a;

   // stop request sent on both channels
   assign controlled_stop_a     = s_r.stop;
   assign controlled_stop_b     = s_r.stop;
   assign controlled_stop_fault = s_r.stop_fault;
   assign safe_out_a            = s_r.out_off ? 4'h0 : s_r.out_req;
   assign safe_out_b            = s_r.out_off ? 4'h0 : s_r.out_req;

   assign key_marker  = s_r.keys;
   assign unit_active = s_r.unit_sel ? 2'b10 : 2'b01;

   // mode selects handwheel or panel permission
   assign unit_ok = s_r.hw_mode ? s_r.marker.permit[`SIO_PERMIT_HW]
                                : s_r.marker.permit[`SIO_PERMIT_PANEL];

   for (genvar g = 0; g < NGROUP; g++) begin : g_grp
      // group guarded when its space's door is open
      // each group maps to exactly one space
      assign group_guard_req[g] = ~s_r.marker.door[s_r.group_map[2*g +: 2]];
      assign group_permit[g] = unit_ok &
         (s_r.hw_mode ? s_r.pb_map[g] : s_r.pb_map[4+g]);
   end

endmodule
`default_nettype wire

// file: safe_io_params.svh
// What this block does
// - AND both channels, deliver result and each channel's value
// - Disagreeing channels give combined zero; a forced-sampled input under test follows the other channel
// - Invert each channel before the AND
// - Forced sampling enabled per input by configuration
// - Self-test sampling at most every 168 hours
// - Low level reads zero, the safe state
// - Static levels outside self-test sampling
// - Each computer gets both channels' values
// - Estop or crash starts controlled stop
// - Outputs off during controlled stop at standstill or timeout
// - At most one operating unit active
// - Stop keys never filtered out
// - Filter keys before scan, overwrite markers
// - Requests and acknowledgments on both channels
// - Open doors request safety function per group
// - Report groups with effective permission pressed
// - Operating mode picks effective permission source
// - Either estop channel zero stops, top priority
`ifndef SAFE_IO_PARAMS_SVH
`define SAFE_IO_PARAMS_SVH

`define SIO_CLK_HZ         25000000
`define SIO_SELFTEST_H     168
`define SIO_SCAN_TIME_US   1000
`define SIO_TEST_TIME_US   100
`define SIO_NDOOR          4
`define SIO_NPERMIT        2
`define SIO_NESTOP         2
`define SIO_NSAFE          8
`define SIO_NGROUP         4
`define SIO_NUNIT          2
`define SIO_NKEY           8
`define SIO_NOUT           4
`define SIO_PERMIT_HW      0
`define SIO_PERMIT_PANEL   1
`define SIO_STOP_KEY_MASK  8'h01

`define SIO_REG_INV_A      8'h00
`define SIO_REG_INV_B      8'h04
`define SIO_REG_FSAMP      8'h08
`define SIO_REG_MODE       8'h0c
`define SIO_REG_SAFEOUT    8'h10
`define SIO_REG_TIMEOUT    8'h14
`define SIO_REG_GROUPMAP   8'h18
`define SIO_REG_PBMAP      8'h1c
`define SIO_REG_STATUS     8'h20
`define SIO_REG_MARKERS    8'h24
`define SIO_REG_RAW        8'h28

`define SIO_MODE_HW_BIT    0
`define SIO_MODE_UNIT_BIT  1
`define SIO_MODE_TEST_BIT  8
`define SIO_MODE_CLR_BIT   9
`define SIO_STAT_FAIL_BIT  4
`define SIO_STAT_MISM_BIT  5
`define SIO_TIMEOUT_RST    32'h0000_ffff

`endif

// file: safe_io_pkg.sv
package safe_io_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_type;

   // Bit order of every safe-input vector: estop, permit, door (msb first)
   typedef struct packed {
      logic [1:0] estop;
      logic [1:0] permit;
      logic [3:0] door;
   } marker_type;

   typedef struct packed {
      logic a1;
      logic a2;
      logic b1;
      logic b2;
   } sync_state_type;

   typedef enum logic [1:0] {T_IDLE, T_CHAN_A, T_CHAN_B} test_state_type;

   typedef struct packed {
      logic [7:0]     inv_a;
      logic [7:0]     inv_b;
      logic [7:0]     fsamp;
      logic           hw_mode;
      logic           unit_sel;
      logic [3:0]     out_req;
      logic [31:0]    timeout;
      logic [7:0]     group_map;
      logic [7:0]     pb_map;
      marker_type     marker;
      logic [15:0]    keys;
      logic [15:0]    scan_cnt;
      logic [47:0]    st_cnt;
      test_state_type tst;
      logic [15:0]    tst_cnt;
      logic           tst_fail;
      logic           stop;
      logic           stop_fault;
      logic [31:0]    off_cnt;
      logic           out_off;
      logic           mismatch;
      logic           rsp_err;
      logic [31:0]    rdata;
   } state_type;

endpackage

// file: safe_chan_pair.sv
`timescale 1ns/100ps
`default_nettype none
`include "safe_io_params.svh"

module safe_chan_pair (
   // Clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // Field contacts, one per channel
   input  wire logic pin_a,
   input  wire logic pin_b,
   // Configuration
   input  wire logic inv_a,
   input  wire logic inv_b,
   input  wire logic skip_a,
   input  wire logic skip_b,
   // Results
   output logic      raw_a,
   output logic      raw_b,
   output logic      view_a,
   output logic      view_b,
   output logic      combined
);
   safe_io_pkg::sync_state_type s_r, s_nxt;

   always_comb begin
      s_nxt    = s_r;
      s_nxt.a1 = pin_a;
      s_nxt.a2 = s_r.a1;
      s_nxt.b1 = pin_b;
      s_nxt.b2 = s_r.b1;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign raw_a  = s_r.a2;
   assign raw_b  = s_r.b2;
   assign view_a = s_r.a2 ^ inv_a;
   assign view_b = s_r.b2 ^ inv_b;
   // AND of both channels; a channel under test defers to the other
   assign combined = (view_a | skip_a) & (view_b | skip_b);

endmodule
`default_nettype wire

// file: safe_io_gating_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module safe_io_gating_asserts (
   // Clock and reset
   input wire logic                     clk,
   input wire logic                     arst_n,
   // Bus, units and self-test
   input wire safe_io_pkg::apb_req_type apb_req,
   input wire safe_io_pkg::apb_rsp_type apb_rsp,
   input wire logic [15:0]              key_marker,
   input wire logic [1:0]               unit_active,
   input wire logic                     test_out_a,
   input wire logic                     test_out_b,
   // Stop path
   input wire safe_io_pkg::marker_type  marker_a,
   input wire safe_io_pkg::marker_type  marker_b,
   input wire logic                     sw_crash,
   input wire logic                     all_standstill,
   input wire logic                     controlled_stop_a,
   input wire logic                     controlled_stop_b,
   input wire logic                     controlled_stop_fault,
   input wire logic [3:0]               safe_out_a,
   input wire logic [3:0]               safe_out_b
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic clr_wr;
   assign clr_wr = apb_req.psel && apb_req.penable && apb_req.pwrite
                   && apb_req.paddr == 8'h0c && apb_req.pwdata[9];

   property p_same_markers; marker_a == marker_b; endproperty
   a_same_markers: assert property (p_same_markers)
      else $error("channel markers differ");
   property p_estop_stop;
      |(~marker_a.estop & $past(marker_a.estop)) |-> controlled_stop_a && controlled_stop_b;
   endproperty
   a_estop_stop: assert property (p_estop_stop)
      else $error("estop marker fell without stop");
   property p_stop_holds; controlled_stop_a && !clr_wr |=> controlled_stop_a; endproperty
   a_stop_holds: assert property (p_stop_holds)
      else $error("stop dropped without clear");
   property p_crash; sw_crash |-> ##[0:2] (controlled_stop_fault && controlled_stop_a); endproperty
   a_crash: assert property (p_crash)
      else $error("crash did not start fault stop");
   property p_off;
      controlled_stop_a && all_standstill |-> ##[1:3] (safe_out_a == 4'h0 && safe_out_b == 4'h0);
   endproperty
   a_off: assert property (p_off)
      else $error("outputs on at standstill");
   property p_one_unit; $onehot(unit_active); endproperty
   a_one_unit: assert property (p_one_unit)
      else $error("unit selection not one-hot");
   property p_key_filter;
      $changed(key_marker) |-> ($past(unit_active[1]) || key_marker[15:9] == 7'h00)
         && ($past(unit_active[0]) || key_marker[7:1] == 7'h00);
   endproperty
   a_key_filter: assert property (p_key_filter)
      else $error("keys of idle unit passed");
   property p_test_alt; test_out_a || test_out_b; endproperty
   a_test_alt: assert property (p_test_alt)
      else $error("both test supplies off");
   property p_outs_pair; safe_out_a == safe_out_b; endproperty
   a_outs_pair: assert property (p_outs_pair)
      else $error("safe outputs differ");
   property p_err_phase; apb_rsp.pslverr |-> apb_req.psel && apb_req.penable; endproperty
   a_err_phase: assert property (p_err_phase)
      else $error("slave error outside access");
endmodule
bind safe_io_gating safe_io_gating_asserts u_safe_io_gating_asserts (
   .clk, .arst_n, .apb_req, .apb_rsp, .key_marker, .unit_active, .test_out_a, .test_out_b,
   .marker_a, .marker_b, .sw_crash, .all_standstill, .controlled_stop_a,
   .controlled_stop_b, .controlled_stop_fault, .safe_out_a, .safe_out_b);
`default_nettype wire

// file: field_contacts.sv
`timescale 1ns/100ps
`default_nettype none
module field_contacts #(
   parameter logic [7:0] POWERED = 8'h0f
) (
   // Test supplies
   input wire logic                    test_out_a,
   input wire logic                    test_out_b,
   // Static contact levels, bits of A wired past their supply
   input wire logic [7:0]              lvl_a,
   input wire logic [7:0]              lvl_b,
   input wire logic [7:0]              stuck,
   // Pins
   output safe_io_pkg::marker_type     contact_a,
   output safe_io_pkg::marker_type     contact_b
);
   assign contact_a = lvl_a & ~(POWERED & ~stuck & {8{~test_out_a}});
   assign contact_b = lvl_b & ~(POWERED & {8{~test_out_b}});
endmodule
`default_nettype wire

// file: safe_io_gating_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module safe_io_gating_tb_top;
   logic                     clk = 1'b0;
   logic                     arst_n = 1'b0;
   safe_io_pkg::apb_req_type req = '0;
   safe_io_pkg::apb_rsp_type rsp, rsp_s;
   safe_io_pkg::marker_type  ca, cb, ma, mb;
   logic [7:0]               la = 8'hcf, lb = 8'hcf, stuck = 8'h00;
   logic [7:0]               va_o, va_x, vb_o, vb_x;
   logic                     to, tb, crash = 1'b0, still = 1'b0, cs_a, cs_b, csf, e;
   logic [3:0]               gg, gp, so_a, so_b;
   logic [15:0]              keys = 16'h0000, km;
   logic [1:0]               ua;
   logic [31:0]              q;
   int                       n_errors = 0, num_checks = 0;

   always #20 clk = ~clk;
   // Settled copy of the answer, as it stands at the next rising edge
   always @(negedge clk) rsp_s = rsp;

   // Kernel answers every stop request on both channels
   safe_io_gating #(.SCAN_CYC(16'd8), .TEST_CYC(16'd4), .ST_CYC(48'd4000)) u_safe_io_gating (
      .clk(clk), .arst_n(arst_n), .apb_req(req), .apb_rsp(rsp),
      .contact_a(ca), .contact_b(cb), .test_out_a(to), .test_out_b(tb),
      .marker_a(ma), .marker_b(mb), .view_a_own(va_o), .view_a_other(va_x),
      .view_b_own(vb_o), .view_b_other(vb_x), .sw_crash(crash),
      .all_standstill(still), .stop_ack_a(cs_a), .stop_ack_b(cs_b),
      .controlled_stop_a(cs_a), .controlled_stop_b(cs_b), .controlled_stop_fault(csf),
      .group_guard_req(gg), .group_permit(gp), .safe_out_a(so_a), .safe_out_b(so_b),
      .keys_in(keys), .key_marker(km), .unit_active(ua));

   field_contacts u_field_contacts (
      .test_out_a(to), .test_out_b(tb), .lvl_a(la), .lvl_b(lb), .stuck(stuck),
      .contact_a(ca), .contact_b(cb));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Waits for pready as long as it takes; only the watchdog ends a hang
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      @(posedge clk);
      while (rsp_s.pready !== 1'b1) begin
         @(posedge clk);
      end
      q = rsp_s.prdata;
      e = rsp_s.pslverr;
      req <= '0;
      @(posedge clk);
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      #(40 * 20000);
      n_errors++;
      final_report();
   end

   initial begin
      logic [7:0] x;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, 8'h14, 0);
      chk(q, 32'h0000ffff);
      chk(ua, 2'b01);
      bus(1'b0, 8'h30, 0);
      chk(q, 32'h0000_0000);
      chk(e, 1'b1);
      bus(1'b1, 8'h08, 32'h0f);
      // Each axis group lives in a space of its own
      bus(1'b1, 8'h18, 32'he4);
      bus(1'b1, 8'h1c, 32'ha3);
      for (int i = 0; i < 16; i++) begin
         la <= {7'h67, i[0]};
         lb <= {7'h67, i[1]};
         bus(1'b1, 8'h00, {31'h0, i[2]});
         bus(1'b1, 8'h04, {31'h0, i[3]});
         cyc(16);
         x = {7'h67, (i[0] ^ i[2]) & (i[1] ^ i[3])};
         chk(ma, x);
         chk(mb, x);
         chk(va_o[0], i[0] ^ i[2]);
         chk({va_o, vb_o}, {7'h67, i[0] ^ i[2], 7'h67, i[1] ^ i[3]});
         chk({vb_x, va_x}, {7'h67, i[0] ^ i[2], 7'h67, i[1] ^ i[3]});
      end
      bus(1'b1, 8'h00, 0);
      bus(1'b1, 8'h04, 0);
      for (int d = 0; d < 4; d++) begin
         la <= 8'hcf ^ (8'h01 << d);
         lb <= 8'hcf ^ (8'h01 << d);
         cyc(14);
         chk(gg, 4'h1 << d);
      end
      for (int j = 0; j < 4; j++) begin
         bus(1'b1, 8'h0c, {31'h0, j[0]});
         la <= j[1] ? 8'hef : 8'hdf;
         lb <= j[1] ? 8'hef : 8'hdf;
         cyc(14);
         chk(gp, j == 1 ? 4'h3 : j == 2 ? 4'ha : 4'h0);
      end
      la <= 8'hcf;
      lb <= 8'hcf;
      keys <= 16'hffff;
      for (int u = 0; u < 2; u++) begin
         bus(1'b1, 8'h0c, {30'h0, u[0], 1'b0});
         cyc(14);
         chk(km, u ? 16'hff01 : 16'h01ff);
         chk(ua, u ? 2'b10 : 2'b01);
      end
      // Stop is latched since reset, while the estop pins were still syncing in
      bus(1'b1, 8'h0c, 32'h200);
      bus(1'b1, 8'h10, 32'hf);
      bus(1'b1, 8'h14, 32'd20);
      cyc(4);
      chk({so_a, so_b}, 8'hff);
      la <= 8'h4f;
      cyc(5);
      chk({cs_a, cs_b}, 2'b11);
      cyc(8);
      chk(so_a, 4'hf);
      cyc(12);
      chk({so_a, so_b}, 8'h00);
      bus(1'b0, 8'h20, 0);
      chk(q[2:0], 3'b101);
      bus(1'b1, 8'h0c, 32'h200);
      cyc(2);
      chk(cs_a, 1'b1);
      la <= 8'hcf;
      cyc(6);
      bus(1'b1, 8'h0c, 32'h200);
      cyc(2);
      chk(cs_a, 1'b0);
      still <= 1'b1;
      lb <= 8'hbf;
      cyc(8);
      chk(cs_b, 1'b1);
      chk({so_a, so_b}, 8'h00);
      lb <= 8'hcf;
      still <= 1'b0;
      crash <= 1'b1;
      cyc(4);
      chk(csf, 1'b1);
      bus(1'b1, 8'h0c, 32'h200);
      cyc(2);
      chk(cs_a, 1'b1);
      crash <= 1'b0;
      bus(1'b1, 8'h0c, 32'h200);
      cyc(2);
      chk({csf, cs_a}, 2'b00);
      bus(1'b1, 8'h0c, 32'h100);
      for (int n = 0; n < 20 && to !== 1'b0; n++) @(posedge clk);
      chk({to, ma}, 9'h0cf);
      cyc(20);
      bus(1'b0, 8'h20, 0);
      chk(q[4], 1'b0);
      stuck <= 8'h01;
      bus(1'b1, 8'h0c, 32'h100);
      cyc(20);
      bus(1'b0, 8'h20, 0);
      chk(q[4], 1'b1);
      stuck <= 8'h00;
      bus(1'b1, 8'h20, 32'h10);
      bus(1'b0, 8'h20, 0);
      chk(q[4], 1'b0);
      for (int n = 0; n < 5000 && tb !== 1'b0; n++) @(posedge clk);
      chk(tb, 1'b0);
      cyc(20);
      final_report();
   end
endmodule
`default_nettype wire
